// ### design/bsr_burst_sram_rw_sequencer.sv
// top of the burst sram read/write sequencer
`timescale 1ns/1ns
`include "bsr_params.svh"

module bsr_burst_sram_rw_sequencer (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset,
  input  wire bsr_pkg::bsr_req_type      i_req,
  input  wire logic [`BSR_DATA_W-1:0]    i_wr_data,
  input  wire logic                      i_byte_write_strobe_n,
  output logic                           o_kclk_primary,
  output logic                           o_mem_we,
  output logic [`BSR_MADDR_W-1:0]        o_mem_waddr,
  output logic [`BSR_DATA_W-1:0]         o_mem_wdata,
  output logic                           o_mem_re,
  output logic [`BSR_MADDR_W-1:0]        o_mem_raddr,
  input  wire logic [`BSR_DATA_W-1:0]    i_mem_rdata,
  output logic                           o_rd_valid,
  input  wire logic                      i_rd_ready,
  output logic [`BSR_DATA_W-1:0]         o_rd_data,
  output logic                           o_idle_cycle
);
  import bsr_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                       phase_reg;    // high on primary edge
  logic                       last_rd_reg;  // read began last edge
  logic                       last_wr_reg;  // write began last edge
  logic                       rd_start;     // read request valid
  logic                       wr_start;     // write request valid
  logic                       rd_taken;     // read machine took it
  logic                       wr_taken;     // write machine took it
  logic                       rd_active;    // read beats running
  logic                       wr_active;    // write beats running
  logic                       rd_queued;    // read chained
  logic                       wr_queued;    // write chained
  logic [`BSR_BEAT_W-1:0]     rd_beat;      // read beat index
  logic [`BSR_BEAT_W-1:0]     wr_beat;      // write beat index
  logic [`BSR_ADDR_W-1:0]     rd_base;      // read base address
  logic [`BSR_ADDR_W-1:0]     wr_base;      // write base address
  logic                       buf_ready;    // buffer has room
  logic                       rd_hold;      // stall read beats
  bsr_wbeat_type              wbeat_reg;    // write beat to array

  // ----------------------------------------------------------------
  // primary / complementary edge divider
  // ----------------------------------------------------------------
  // each core cycle is one input edge; the primary edges are the
  // cycles with phase_reg high, the complementary ones the others
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase_reg <= 1'b1;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  assign o_kclk_primary = phase_reg;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // requests count only on primary edges; read wins a tie and a
  // repeat of the same kind one edge later is dropped
  assign rd_start = phase_reg && !i_req.read_req_n
                    && !last_rd_reg;
  assign wr_start = phase_reg && i_req.read_req_n
                    && !i_req.write_req_n
                    && !last_wr_reg;
  assign o_idle_cycle = phase_reg && i_req.read_req_n
                        && i_req.write_req_n;

  // remember what began on this primary edge until the next one
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      last_rd_reg <= 1'b0;
      last_wr_reg <= 1'b0;
    end else if (phase_reg) begin
      last_rd_reg <= rd_taken;
      last_wr_reg <= wr_taken;
    end
  end

  // ----------------------------------------------------------------
  // burst machines, one per direction
  // ----------------------------------------------------------------
  // independent instances so a read and a write overlap freely
  bsr_burst_seq u_rd_seq (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_start    (rd_start),
    .i_addr     (i_req.addr),
    .i_hold     (rd_hold),
    .o_taken    (rd_taken),
    .o_active   (rd_active),
    .o_queued   (rd_queued),
    .o_beat     (rd_beat),
    .o_base     (rd_base)
  );

  bsr_burst_seq u_wr_seq (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_start    (wr_start),
    .i_addr     (i_req.addr),
    .i_hold     (1'b0),
    .o_taken    (wr_taken),
    .o_active   (wr_active),
    .o_queued   (wr_queued),
    .o_beat     (wr_beat),
    .o_base     (wr_base)
  );

  // ----------------------------------------------------------------
  // write beat capture
  // ----------------------------------------------------------------
  // data and strobe are sampled in the beat's own cycle, so each
  // beat carries its own mask
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wbeat_reg <= '0;
    end else begin
      wbeat_reg.we   <= wr_active
                        && !i_byte_write_strobe_n;
      wbeat_reg.addr <= {wr_base, wr_beat};
      wbeat_reg.data <= i_wr_data;
    end
  end

  assign o_mem_we    = wbeat_reg.we;
  assign o_mem_waddr = wbeat_reg.addr;
  assign o_mem_wdata = wbeat_reg.data;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // the array answers in the same cycle; the word enters the buffer
  // and appears on the output one cycle later; a full buffer stalls
  // the read beats so that no word is lost
  assign rd_hold     = !buf_ready;
  assign o_mem_re    = rd_active && buf_ready;
  assign o_mem_raddr = {rd_base, rd_beat};

  bsr_pair_buf u_rd_buf (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_valid  (o_mem_re),
    .o_in_ready  (buf_ready),
    .i_in_data   (i_mem_rdata),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // masked beat never reaches the array
  chk_mask_blocks_write: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (wr_active && i_byte_write_strobe_n) |=> !o_mem_we)
    else $error("masked write beat was stored");

  // unmasked beat stores exactly the data of that cycle
  chk_beat_own_data: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (wr_active && !i_byte_write_strobe_n) |=>
      (o_mem_we && (o_mem_wdata == $past(i_wr_data))))
    else $error("write beat data or strobe mismatch");

  // low address bits carry the beat, upper bits the base
  chk_addr_extend: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    wr_active |=> (o_mem_waddr ==
      {$past(wr_base), $past(wr_beat)}))
    else $error("write address not base plus beat");

  // write burst runs 0,1,2,3 starting two cycles after the edge
  chk_write_order: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    wr_taken |-> ##2 (wr_active && wr_beat == 2'h0)
      ##1 (wr_beat == 2'h1) ##1 (wr_beat == 2'h2)
      ##1 (wr_beat == 2'h3))
    else $error("write burst order broken");

  // burst stops by itself after beat three
  chk_auto_end: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (wr_active && wr_beat == 2'h3 && !wr_queued) |=> !wr_active)
    else $error("write burst ran past four beats");

  // a read start does not disturb a write mid-burst
  chk_concurrent: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (rd_taken && wr_active && wr_beat != 2'h3) |=>
      (wr_active && wr_beat == $past(wr_beat) + 2'h1))
    else $error("read start disturbed write burst");

  // read beats the write on a shared edge
  chk_read_wins: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (phase_reg && !i_req.read_req_n && !i_req.write_req_n)
      |-> !wr_taken)
    else $error("write started beside a read request");

  // starts happen only on primary edges
  chk_primary_edge: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (rd_taken || wr_taken) |-> phase_reg)
    else $error("start off the primary edge");

  // both requests high starts nothing
  chk_idle_cycle: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_idle_cycle |-> !(rd_start || wr_start))
    else $error("idle cycle started a burst");

  // with room in the buffer, the first read word shows at cycle 3
  chk_read_latency: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (rd_taken && !rd_active && !rd_queued && !o_rd_valid
      && i_rd_ready) ##1 i_rd_ready[*2] |-> ##1 o_rd_valid)
    else $error("read word late");

  // a second same-kind request one edge later is ignored
  chk_repeat_ignored: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    rd_taken |-> ##2 !rd_taken)
    else $error("back-to-back read accepted");

  // the same holds for a repeated write
  chk_wr_repeat: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    wr_taken |-> ##2 !wr_taken)
    else $error("back-to-back write accepted");

  // an unstalled read beat steps up by one
  chk_read_step: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (rd_active && !rd_hold && rd_beat != 2'h3) |=>
      (rd_active && rd_beat == $past(rd_beat) + 2'h1))
    else $error("read burst order broken");

  // a stalled read keeps its beat and base
  chk_stall_hold: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (rd_active && rd_hold) |=>
      (rd_active && $stable(rd_beat) && $stable(rd_base)))
    else $error("stalled read beat moved");

  // no array read in the lead cycle of a fresh read
  chk_read_lead: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (rd_taken && !rd_active) |=> !o_mem_re)
    else $error("read beat came one cycle early");

  // no write beat in the lead cycle of a fresh write
  chk_write_lead: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (wr_taken && !wr_active) |=> !wr_active)
    else $error("write beat came one cycle early");

  // ----------------------------------------------------------------
  // scenario covers
  // ----------------------------------------------------------------
  cov_read_write_overlap: cover property (
    @(posedge i_core_clk) disable iff (i_reset)
    rd_active && wr_active);

  cov_read_chained: cover property (
    @(posedge i_core_clk) disable iff (i_reset)
    rd_active && rd_queued);

  cov_read_stall: cover property (
    @(posedge i_core_clk) disable iff (i_reset)
    rd_active && rd_hold);

  cov_masked_beat: cover property (
    @(posedge i_core_clk) disable iff (i_reset)
    wr_active && i_byte_write_strobe_n);

  // a write queued behind a running write
  cov_write_chained: cover property (
    @(posedge i_core_clk) disable iff (i_reset)
    wr_active && wr_queued);

endmodule

// ### design/bsr_params.svh
// constants for the burst sram read/write sequencer
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BSR_DATA_W    9
`define BSR_ADDR_W    20
`define BSR_BEAT_W    2
`define BSR_MADDR_W   22

// ----------------------------------------------------------------
// burst and timing
// ----------------------------------------------------------------
`define BSR_FIRST_BEAT 2'h0
`define BSR_LAST_BEAT  2'h3
`define BSR_BEAT_STEP  2'h1
`define BSR_CLK_NS     100
`define BSR_BUF_DEPTH  2

`endif

// ### design/bsr_pkg.sv
// types shared by the burst sram read/write sequencer
`include "bsr_params.svh"

package bsr_pkg;

  // burst machine states
  typedef enum logic [1:0] {
    BSR_IDLE,
    BSR_LEAD,
    BSR_BURST
  } bsr_state_type;

  // one write beat handed to the storage array
  typedef struct packed {
    logic                      we;
    logic [`BSR_MADDR_W-1:0]   addr;
    logic [`BSR_DATA_W-1:0]    data;
  } bsr_wbeat_type;

  // request lines from the memory controller
  typedef struct packed {
    logic                      read_req_n;
    logic                      write_req_n;
    logic [`BSR_ADDR_W-1:0]    addr;
  } bsr_req_type;

endpackage

// ### design/bsr_burst_seq.sv
// one four-beat burst machine, used once per direction
`timescale 1ns/1ns
`include "bsr_params.svh"

module bsr_burst_seq (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_start,
  input  wire logic [`BSR_ADDR_W-1:0]  i_addr,
  input  wire logic                    i_hold,
  output logic                         o_taken,
  output logic                         o_active,
  output logic                         o_queued,
  output logic [`BSR_BEAT_W-1:0]       o_beat,
  output logic [`BSR_ADDR_W-1:0]       o_base
);
  import bsr_pkg::*;

  bsr_state_type              state_reg;   // machine state
  logic [`BSR_BEAT_W-1:0]     beat_reg;    // beat index in burst
  logic [`BSR_ADDR_W-1:0]     base_reg;    // burst base address
  logic [`BSR_ADDR_W-1:0]     qbase_reg;   // next burst, waiting
  logic                       qvalid_reg;  // next burst pending
  logic                       last_beat;   // final beat moving on

  assign last_beat = (state_reg == BSR_BURST) && !i_hold
                     && (beat_reg == `BSR_LAST_BEAT);
  // a start is taken when idle or when one slot is free mid-burst
  assign o_taken  = i_start && ((state_reg == BSR_IDLE)
                    || ((state_reg == BSR_BURST) && !qvalid_reg));
  assign o_active = (state_reg == BSR_BURST);
  assign o_queued = qvalid_reg;
  assign o_beat   = beat_reg;
  assign o_base   = base_reg;

  // ----------------------------------------------------------------
  // state and beat counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= BSR_IDLE;
      beat_reg  <= `BSR_FIRST_BEAT;
      base_reg  <= '0;
    end else begin
      case (state_reg)
        BSR_IDLE: begin
          // latch base, wait one cycle before first beat
          if (o_taken) begin
            base_reg  <= i_addr;
            state_reg <= BSR_LEAD;
          end
        end
        BSR_LEAD: begin
          if (!i_hold) begin
            state_reg <= BSR_BURST;
            beat_reg  <= `BSR_FIRST_BEAT;
          end
        end
        BSR_BURST: begin
          if (last_beat) begin
            // four beats done: chain, restart or stop
            beat_reg <= `BSR_FIRST_BEAT;
            if (qvalid_reg) begin
              base_reg <= qbase_reg;
            end else if (o_taken) begin
              base_reg  <= i_addr;
              state_reg <= BSR_LEAD;
            end else begin
              state_reg <= BSR_IDLE;
            end
          end else if (!i_hold) begin
            beat_reg <= beat_reg + `BSR_BEAT_STEP;
          end
        end
        default: state_reg <= BSR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pending burst slot
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      qvalid_reg <= 1'b0;
      qbase_reg  <= '0;
    end else if (last_beat && qvalid_reg) begin
      qvalid_reg <= 1'b0;
    end else if (o_taken && (state_reg == BSR_BURST) && !last_beat) begin
      qvalid_reg <= 1'b1;
      qbase_reg  <= i_addr;
    end
  end

endmodule

// ### design/bsr_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`include "bsr_params.svh"

module bsr_pair_buf (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_in_valid,
  output logic                         o_in_ready,
  input  wire logic [`BSR_DATA_W-1:0]  i_in_data,
  output logic                         o_out_valid,
  input  wire logic                    i_out_ready,
  output logic [`BSR_DATA_W-1:0]       o_out_data
);
  import bsr_pkg::*;

  logic [`BSR_DATA_W-1:0]  slot_reg [`BSR_BUF_DEPTH];  // storage
  logic [1:0]              count_reg;   // words held
  logic                    push;        // word enters
  logic                    pop;         // word leaves

  assign o_in_ready  = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data  = slot_reg[0];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // ----------------------------------------------------------------
  // occupancy
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count_reg <= 2'h0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 2'h1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // slots: head at index 0, shift on pop
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end else begin
      if (pop) begin
        slot_reg[0] <= (count_reg == 2'h2) ? slot_reg[1] : i_in_data;
      end else if (push && (count_reg == 2'h0)) begin
        slot_reg[0] <= i_in_data;
      end
      if (push && (count_reg == (pop ? 2'h2 : 2'h1))) begin
        slot_reg[1] <= i_in_data;
      end
    end
  end

endmodule

// ### verification/bsr_ctl_model.sv
// memory controller model: requests, write beats and read-side ready
`timescale 1ns/1ns
`include "bsr_params.svh"

module bsr_ctl_model (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_kclk_primary,
  output bsr_pkg::bsr_req_type         o_req,
  output logic [`BSR_DATA_W-1:0]       o_wr_data,
  output logic                         o_byte_write_strobe_n,
  output logic                         o_rd_ready
);
  import bsr_pkg::*;
  int                    cyc = 0;       // free-running cycle number
  logic                  rdy = 1'h1;    // consumer ready wanted by the bench
  logic                  pv [16];       // planned beat present
  logic [`BSR_DATA_W-1:0] pd [16];      // planned beat data
  logic                  ps [16];       // planned beat strobe

  // ----------------------------------------------------------------
  // idle levels and beat plan
  // ----------------------------------------------------------------
  initial begin
    o_req = '{1'h1, 1'h1, 20'h00000};
    o_wr_data = 9'h000;
    o_byte_write_strobe_n = 1'h1;
    o_rd_ready = 1'h1;
    foreach (pv[i]) pv[i] = 1'h0;
  end

  // cycle counter shared with the bench
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
  end

  // ready changes only off the sampling edge
  always @(negedge i_core_clk) begin
    o_rd_ready <= rdy;
  end

  // one data beat and its own strobe per planned cycle
  always @(negedge i_core_clk) begin
    if (pv[cyc % 16]) begin
      o_wr_data <= pd[cyc % 16];
      o_byte_write_strobe_n <= ps[cyc % 16];
      pv[cyc % 16] = 1'h0;
    end else begin
      // released lines show no stale value
      o_wr_data <= ~o_wr_data;
      o_byte_write_strobe_n <= ~o_byte_write_strobe_n;
    end
  end

  // one request for one cycle; beats go on cycles c0+2..c0+5
  task automatic issue(input logic rd_n, input logic wr_n,
                       input logic [19:0] a, input logic [35:0] d,
                       input logic [3:0] s, input bit anyc,
                       input bit plan, output int c0);
    int idx;
    do @(negedge i_core_clk);
    while (i_kclk_primary !== (anyc ? 1'h0 : 1'h1));
    o_req <= '{rd_n, wr_n, a};
    c0 = cyc;
    if (!wr_n && plan) begin
      for (int k = 0; k < 4; k++) begin
        idx = (cyc + 2 + k) % 16;
        pv[idx] = 1'h1;
        pd[idx] = d[9*k +: 9];
        ps[idx] = s[k];
      end
    end
    @(negedge i_core_clk);
    o_req <= '{1'h1, 1'h1, ~a};
  endtask
endmodule

// ### verification/bsr_burst_sram_rw_sequencer_tb.sv
// self-checking bench for the burst sram read/write sequencer
`timescale 1ns/1ns
`include "bsr_params.svh"

module bsr_burst_sram_rw_sequencer_tb;
  import bsr_pkg::*;
  typedef struct packed {
    logic rd_n; logic wr_n; logic [19:0] a;
    logic [35:0] d; logic [3:0] s; logic [3:0] we;
  } bsr_row_type;
  typedef struct { logic [21:0] a; logic [8:0] d; int c; } bsr_exp_type;

  logic                 i_core_clk = 1'h0;   // 10 MHz core clock
  logic                 i_reset = 1'h1;      // synchronous reset
  bsr_req_type          req;                 // request group
  logic [8:0]           wr_data;             // write beat data
  logic                 strb_n;              // beat strobe
  logic                 prim, we, re, rd_valid, rd_ready, idle;
  logic [21:0]          waddr, raddr;        // array addresses
  logic [8:0]           wdata, rdata, rd_data;
  int                   failures = 0;
  int                   n_tests = 0;
  bit                   rtime = 1'h1;        // read cycle check enabled
  bsr_exp_type          wq[$], rq[$], dq[$]; // expected beats
  bsr_exp_type          we_e, re_e, rd_e;

  // ----------------------------------------------------------------
  // clock, array model, design and partner
  // ----------------------------------------------------------------
  always #50 i_core_clk = ~i_core_clk;

  function automatic logic [8:0] rdat(logic [21:0] a);
    return a[8:0] ^ a[21:13];
  endfunction
  assign rdata = rdat(raddr);

  bsr_burst_sram_rw_sequencer dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_req(req),
    .i_wr_data(wr_data), .i_byte_write_strobe_n(strb_n),
    .o_kclk_primary(prim), .o_mem_we(we), .o_mem_waddr(waddr),
    .o_mem_wdata(wdata), .o_mem_re(re), .o_mem_raddr(raddr),
    .i_mem_rdata(rdata), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready),
    .o_rd_data(rd_data), .o_idle_cycle(idle));

  bsr_ctl_model ctl (
    .i_core_clk(i_core_clk), .i_kclk_primary(prim), .o_req(req),
    .o_wr_data(wr_data), .o_byte_write_strobe_n(strb_n),
    .o_rd_ready(rd_ready));

  // ----------------------------------------------------------------
  // compare tasks and verdict
  // ----------------------------------------------------------------
  task automatic cmp22(string nm, logic [21:0] e, logic [21:0] v);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic cmp9(string nm, logic [8:0] e, logic [8:0] v);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic cmp1(string nm, logic e, logic v);
    n_tests++;
    if (v !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // issue one row and list the beats it should give
  task automatic op(bsr_row_type r, bit anyc, bit plan, bit expect_it);
    int c0;
    ctl.issue(r.rd_n, r.wr_n, r.a, r.d, r.s, anyc, plan, c0);
    for (int k = 0; k < 4; k++) begin
      if (expect_it && !r.rd_n) begin
        rq.push_back('{{r.a, 2'(k)}, rdat({r.a, 2'(k)}), c0 + 2 + k});
        dq.push_back('{{r.a, 2'(k)}, rdat({r.a, 2'(k)}), 0});
      end else if (expect_it && r.we[k]) begin
        wq.push_back('{{r.a, 2'(k)}, r.d[9*k +: 9], c0 + 3 + k});
      end
    end
  endtask

  // wait out a burst and see every expected beat consumed
  task automatic settle();
    repeat (12) @(negedge i_core_clk);
    cmp1("pending", 1'h1, logic'(wq.size() + rq.size() + dq.size() == 0));
  endtask

  // ----------------------------------------------------------------
  // monitors: array strobes at negedge, read words at posedge
  // ----------------------------------------------------------------
  always @(negedge i_core_clk) begin
    if (we === 1'h1 && wq.size() == 0) begin
      cmp1("o_mem_we", 1'h0, we);
    end else if (we === 1'h1) begin
      we_e = wq.pop_front();
      cmp22("o_mem_waddr", we_e.a, waddr);
      cmp9("o_mem_wdata", we_e.d, wdata);
      cmp22("write cycle", 22'(we_e.c), 22'(ctl.cyc));
    end
    if (re === 1'h1 && rq.size() == 0) begin
      cmp1("o_mem_re", 1'h0, re);
    end else if (re === 1'h1) begin
      re_e = rq.pop_front();
      cmp22("o_mem_raddr", re_e.a, raddr);
      if (rtime) cmp22("read cycle", 22'(re_e.c), 22'(ctl.cyc));
    end
  end
  always @(posedge i_core_clk) begin
    if (rd_valid === 1'h1 && rd_ready === 1'h1 && dq.size() == 0) begin
      cmp1("o_rd_valid", 1'h0, rd_valid);
    end else if (rd_valid === 1'h1 && rd_ready === 1'h1) begin
      rd_e = dq.pop_front();
      cmp9("o_rd_data", rd_e.d, rd_data);
    end
  end

  // ----------------------------------------------------------------
  // ordinary cases: write, masked write, reads, both low, idle
  // ----------------------------------------------------------------
  bsr_row_type rows [7] = '{
    '{1'h1, 1'h0, 20'h00003, 36'h123456789, 4'h0, 4'hF},
    '{1'h1, 1'h0, 20'hFFFFF, 36'hABCDE0123, 4'h5, 4'hA},
    '{1'h1, 1'h0, 20'h40000, 36'h1FF00FF00, 4'hF, 4'h0},
    '{1'h0, 1'h1, 20'h00003, 36'h000000000, 4'h0, 4'h0},
    '{1'h0, 1'h1, 20'hFFFFF, 36'h000000000, 4'h0, 4'h0},
    '{1'h0, 1'h0, 20'h12345, 36'h55555AAAA, 4'h0, 4'h0},
    '{1'h1, 1'h1, 20'h0F0F0, 36'h0F0F0F0F0, 4'h0, 4'h0}
  };

  initial begin
    // reset held for 12 cycles, outputs checked while held
    repeat (12) @(negedge i_core_clk);
    cmp1("o_kclk_primary", 1'h1, prim);
    cmp1("o_mem_we", 1'h0, we);
    cmp1("o_rd_valid", 1'h0, rd_valid);
    i_reset = 1'h0;
    foreach (rows[i]) begin
      op(rows[i], 1'h0, 1'h1, 1'h1);
      settle();
    end
    // idle flag only on primary cycles with no request
    do @(negedge i_core_clk); while (prim !== 1'h1);
    cmp1("o_idle_cycle", 1'h1, idle);
    @(negedge i_core_clk);
    cmp1("o_idle_cycle", 1'h0, idle);
    // request outside a primary cycle is not taken
    op(rows[3], 1'h1, 1'h1, 1'h0);
    settle();
    // same kind on the next primary ignored, one later chains
    op(rows[3], 1'h0, 1'h1, 1'h1);
    op(rows[3], 1'h0, 1'h1, 1'h0);
    op(rows[4], 1'h0, 1'h1, 1'h1);
    settle();
    op(rows[0], 1'h0, 1'h1, 1'h1);
    op(rows[1], 1'h0, 1'h0, 1'h0);
    op(rows[1], 1'h0, 1'h1, 1'h1);
    settle();
    // write and read bursts overlapping
    op(rows[0], 1'h0, 1'h1, 1'h1);
    op(rows[4], 1'h0, 1'h1, 1'h1);
    settle();
    // consumer stalls: buffer fills, array reads pause
    rtime = 1'h0;
    ctl.rdy = 1'h0;
    op(rows[4], 1'h0, 1'h1, 1'h1);
    repeat (10) @(negedge i_core_clk);
    cmp1("o_rd_valid", 1'h1, rd_valid);
    cmp1("o_mem_re", 1'h0, re);
    ctl.rdy = 1'h1;
    settle();
    rtime = 1'h1;
    // reset in mid burst ends it
    op(rows[0], 1'h0, 1'h1, 1'h1);
    repeat (3) @(negedge i_core_clk);
    i_reset = 1'h1;
    @(negedge i_core_clk);
    wq.delete();
    rq.delete();
    dq.delete();
    cmp1("o_mem_we", 1'h0, we);
    @(negedge i_core_clk);
    i_reset = 1'h0;
    settle();
    close_out();
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(3000 * 100);
    failures++;
    close_out();
  end
endmodule
